// ---- core/mcp_core.sv ----
// Master clock selection, prescaling, gating, clock guard and low-power sequencing.
// Assumes AHB-Lite master on clock_in; oscillator ticks and ready flags synchronous.
`timescale 1ns/1ps

module mcp_core
  import mcp_pkg::*;
#(
  parameter int unsigned GUARD_LSI_TICKS = 4,
  parameter int unsigned GUARD_W         = 8
) (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire mcp_ahb_in_t ahb_in,
  input  wire mcp_osc_t    osc_in,
  input  wire mcp_wake_t   wake_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             master_tick_out,
  output logic             cpu_tick_out,
  output logic             mem_tick_out,
  output logic [7:0]       periph_one_tick_out,
  output logic [7:0]       periph_two_tick_out,
  output logic             clock_out_pin_drive_out,
  output logic             clock_out_oe_out,
  output logic             regulator_on_out,
  output logic             irq_out
);

  function automatic logic is_external(input mcp_src_t src);
    is_external = (src == SRC_XTAL) || (src == SRC_UEXT);
  endfunction

  function automatic logic [CNT_W-1:0] terminal(input logic [PRE_W-1:0] pre);
    terminal = CNT_W'((8'h01 << pre) - 8'h01);
  endfunction

  // Control state
  mcp_src_t             sel_req;
  mcp_src_t             cur_src;
  logic [PRE_W-1:0]     pre;
  logic                 guard_en;
  logic                 cout_en;
  logic [1:0]           cout_sel;
  logic                 mem_stop;
  logic [1:0]           lpm_sel;
  logic [7:0]           gate_one;
  logic [7:0]           gate_two;
  logic [IRQ_W-1:0]     irq_stat;
  logic [IRQ_W-1:0]     irq_mask;
  mcp_pm_t              pm;
  mcp_pm_t              next_pm;
  logic [CNT_W-1:0]     div_cnt;
  logic [GUARD_W-1:0]   guard_cnt;
  logic [7:0]           wake_cnt;

  // Bus slave state
  logic                 wr_pend;
  logic [AW-1:0]        wr_addr;
  logic                 rd_pend;
  logic [AW-1:0]        rd_addr;

  // Decode nets, declared ahead so any order of use is legal
  logic                 bus_take;
  logic                 take_wr;
  logic                 take_rd;
  logic [31:0]          wd;
  logic                 wr_ctrl;
  logic                 wr_power;
  logic                 wr_g_one;
  logic                 wr_g_two;
  logic                 wr_istat;
  logic                 wr_imask;

  logic                 src_tick;
  logic                 req_ready;
  logic                 busy;
  logic [CNT_W-1:0]     div_term;
  logic                 do_switch;
  logic                 tick_now;
  logic                 guard_armed;
  logic                 ext_tick;
  logic                 slow_tick;
  logic                 guard_fail;
  logic                 cpu_run;
  logic                 periph_run;
  logic                 reg_off;
  logic                 enter_lp;
  logic                 wake_done;
  logic [IRQ_W-1:0]     irq_clr;
  logic [IRQ_W-1:0]     next_irq_stat;
  logic [IRQ_W-1:0]     next_irq_mask;
  logic                 cout_tick;
  logic [31:0]          stat_word;
  logic [31:0]          ctrl_word;
  logic [31:0]          rd_word;

  // Bus decode
  assign bus_take = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
  assign take_wr  = bus_take & ahb_in.hwrite;
  assign take_rd  = bus_take & ~ahb_in.hwrite;
  assign wd       = ahb_in.hwdata;
  assign wr_ctrl  = wr_pend & (wr_addr == OFS_CTRL);
  assign wr_power = wr_pend & (wr_addr == OFS_POWER);
  assign wr_g_one = wr_pend & (wr_addr == OFS_GATE_ONE);
  assign wr_g_two = wr_pend & (wr_addr == OFS_GATE_TWO);
  assign wr_istat = wr_pend & (wr_addr == OFS_IRQ_STAT);
  assign wr_imask = wr_pend & (wr_addr == OFS_IRQ_MASK);

  // Source selection and prescaler
  assign src_tick  = osc_in.tick[cur_src];
  assign req_ready = osc_in.ready[sel_req];
  assign busy      = (sel_req != cur_src);
  assign div_term  = terminal(pre);
  // Change only between periods, so the last old period is always whole
  assign do_switch = busy & req_ready & (div_cnt == '0) & ~src_tick
                     & ~guard_fail; // RULE_02 RULE_03
  assign tick_now  = src_tick & (div_cnt >= div_term); // RULE_01

  // Clock guard: slow RC ticks counted between external edges
  assign guard_armed = guard_en & is_external(cur_src)
                       & ((pm == PM_RUN) | (pm == PM_WAIT));
  assign ext_tick    = src_tick;
  assign slow_tick   = osc_in.tick[SRC_SLOW_RC];
  assign guard_fail  = guard_armed & slow_tick & ~ext_tick
                       & (guard_cnt == GUARD_W'(GUARD_LSI_TICKS - 1)); // RULE_17

  // Power state decode
  assign cpu_run    = (pm == PM_RUN);
  assign periph_run = (pm == PM_RUN) | (pm == PM_WAIT); // RULE_13 RULE_14
  assign reg_off    = (pm == PM_AH_OFF) | (pm == PM_HALT); // RULE_15 RULE_16
  assign enter_lp   = wr_power & wd[PWR_ENTER] & cpu_run;
  assign wake_done  = (wake_cnt == 8'(REG_START_CYC - 1));

  // Interrupt status: hardware set wins over a write-one clear
  wire [IRQ_W-1:0] irq_evt;
  assign irq_evt[IRQ_FAIL]     = guard_fail;
  assign irq_evt[IRQ_SWITCHED] = do_switch;
  assign irq_clr       = wr_istat ? wd[IRQ_W-1:0] : '0;
  assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
  assign next_irq_mask = wr_imask ? wd[IRQ_W-1:0] : irq_mask;

  // Clock output selection
  assign cout_tick = (cout_sel == 2'h0) ? tick_now :
                     (cout_sel == 2'h1) ? osc_in.tick[SRC_FAST_RC] :
                     (cout_sel == 2'h2) ? osc_in.tick[SRC_SLOW_RC] :
                                          osc_in.tick[SRC_XTAL];

  // Read mux
  assign stat_word = (32'(cur_src)          << STAT_SRC_LSB)
                          | (32'(busy)             << STAT_BUSY)
                          | (32'(osc_in.ready)     << STAT_RDY_LSB)
                          | (32'(pm)               << STAT_PM_LSB)
                          | (32'(!reg_off)         << STAT_REG_ON);
  assign ctrl_word = (32'(sel_req)          << CTRL_SRC_LSB)
                          | (32'(pre)              << CTRL_PRE_LSB)
                          | (32'(guard_en)         << CTRL_GUARD)
                          | (32'(cout_en)          << CTRL_COUT_EN)
                          | (32'(cout_sel)         << CTRL_COUT_LSB)
                          | (32'(mem_stop)         << CTRL_MEM_STOP);
  assign rd_word   = (rd_addr == OFS_CTRL)     ? ctrl_word :
                            (rd_addr == OFS_POWER)    ? 32'(lpm_sel) << PWR_MODE_LSB :
                            (rd_addr == OFS_STATUS)   ? stat_word :
                            (rd_addr == OFS_GATE_ONE) ? 32'(gate_one) :
                            (rd_addr == OFS_GATE_TWO) ? 32'(gate_two) :
                            (rd_addr == OFS_IRQ_STAT) ? 32'(irq_stat) :
                            (rd_addr == OFS_IRQ_MASK) ? 32'(irq_mask) :
                                                        32'h0000_0000;

  // Low-power sequencer
  always_comb begin
    next_pm = pm;
    unique case (pm)
      PM_RUN: begin
        if (enter_lp) begin
          unique case (mcp_lpm_t'(wd[PWR_MODE_LSB +: 2]))
            LPM_WAIT:   next_pm = PM_WAIT;
            LPM_AH_ON:  next_pm = PM_AH_ON;
            LPM_AH_OFF: next_pm = PM_AH_OFF;
            LPM_HALT:   next_pm = PM_HALT;
          endcase
        end
      end
      PM_WAIT: begin
        if (wake_in.irq | wake_in.ext_event | irq_out) begin
          next_pm = PM_RUN; // RULE_13
        end
      end
      PM_AH_ON: begin
        if (wake_in.auto_wakeup_unit | wake_in.ext_event) begin
          next_pm = PM_RUN; // RULE_14
        end
      end
      PM_AH_OFF: begin
        if (wake_in.auto_wakeup_unit | wake_in.ext_event) begin
          next_pm = PM_WAKE; // RULE_15
        end
      end
      PM_HALT: begin
        if (wake_in.ext_event) begin
          next_pm = PM_WAKE; // RULE_16
        end
      end
      PM_WAKE: begin
        if (wake_done) begin
          next_pm = PM_RUN;
        end
      end
      default: next_pm = PM_RUN;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pm       <= PM_RUN;
      wake_cnt <= 8'h00;
    end else begin
      pm       <= next_pm;
      wake_cnt <= (pm == PM_WAKE) ? wake_cnt + 8'h01 : 8'h00;
    end
  end

  // AHB-Lite slave: writes land in the data phase, reads take one wait state
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend       <= 1'b0;
      wr_addr       <= '0;
      rd_pend       <= 1'b0;
      rd_addr       <= '0;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend       <= take_wr;
      rd_pend       <= take_rd;
      hresp_out     <= 1'b0;
      if (bus_take) begin
        wr_addr <= ahb_in.haddr[AW-1:0];
        rd_addr <= ahb_in.haddr[AW-1:0];
      end
      if (take_rd) begin
        hreadyout_out <= 1'b0;
      end else if (rd_pend) begin
        hreadyout_out <= 1'b1;
        hrdata_out    <= rd_word;
      end
    end
  end

  // Control register; a guard failure overrides a same-cycle write of source and prescaler
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_req  <= SRC_FAST_RC; // RULE_06
      pre      <= PRE_RESET; // RULE_06
      guard_en <= 1'b0;
      cout_en  <= 1'b0;
      cout_sel <= 2'h0;
      mem_stop <= 1'b0;
      lpm_sel  <= 2'h0;
    end else begin
      if (guard_fail) begin
        sel_req <= SRC_FAST_RC; // RULE_08
        pre     <= PRE_RESET; // RULE_08
      end else if (wr_ctrl) begin
        sel_req <= mcp_src_t'(wd[CTRL_SRC_LSB +: 2]); // RULE_05 RULE_07
        pre     <= wd[CTRL_PRE_LSB +: PRE_W]; // RULE_07
      end
      if (wr_ctrl) begin
        guard_en <= wd[CTRL_GUARD];
        cout_en  <= wd[CTRL_COUT_EN];
        cout_sel <= wd[CTRL_COUT_LSB +: 2];
        mem_stop <= wd[CTRL_MEM_STOP]; // RULE_04
      end
      if (wr_power) begin
        lpm_sel <= wd[PWR_MODE_LSB +: 2];
      end
    end
  end

  // Peripheral gates; reserved bits hold zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_one <= GATE_ONE_RESET & GATE_ONE_MASK;
      gate_two <= GATE_TWO_RESET;
    end else begin
      if (wr_g_one) begin
        gate_one <= wd[7:0] & GATE_ONE_MASK; // RULE_11
      end
      if (wr_g_two) begin
        gate_two <= wd[7:0] & GATE_TWO_MASK; // RULE_12
      end
    end
  end

  // Interrupt status, mask and line
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq_out  <= |(next_irq_stat & next_irq_mask); // RULE_09
    end
  end

  // Source changeover and prescaler counter
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cur_src <= SRC_FAST_RC; // RULE_06
      div_cnt <= '0;
    end else begin
      if (guard_fail) begin
        // Dead source: a partial period cannot be finished anyway
        cur_src <= SRC_FAST_RC; // RULE_08
        div_cnt <= '0;
      end else if (do_switch) begin
        cur_src <= sel_req; // RULE_02
      end else if (src_tick) begin
        div_cnt <= tick_now ? '0 : div_cnt + CNT_W'(1); // RULE_01
      end
    end
  end

  // External clock guard counter
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      guard_cnt <= '0;
    end else if (!guard_armed || ext_tick || guard_fail) begin
      guard_cnt <= '0; // RULE_17
    end else if (slow_tick) begin
      guard_cnt <= guard_cnt + GUARD_W'(1);
    end
  end

  // Gated clock enables, all registered
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      master_tick_out     <= 1'b0;
      cpu_tick_out        <= 1'b0;
      mem_tick_out        <= 1'b0;
      periph_one_tick_out <= 8'h00;
      periph_two_tick_out <= 8'h00;
      regulator_on_out    <= 1'b1;
    end else begin
      master_tick_out     <= tick_now;
      cpu_tick_out        <= tick_now & cpu_run; // RULE_04 RULE_13
      mem_tick_out        <= tick_now & periph_run & ~mem_stop; // RULE_04
      periph_one_tick_out <= {8{tick_now & periph_run}} & gate_one; // RULE_11 RULE_14
      periph_two_tick_out <= {8{tick_now & periph_run}} & gate_two; // RULE_12 RULE_16
      // From the settled mode, so it never drops while ticks still leave
      regulator_on_out    <= ~reg_off; // RULE_15
    end
  end

  // Clock output pin: half the rate of the chosen tick, low when off
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_out_pin_drive_out <= 1'b0;
      clock_out_oe_out        <= 1'b0;
    end else begin
      clock_out_oe_out <= cout_en; // RULE_10
      if (!cout_en) begin
        clock_out_pin_drive_out <= 1'b0;
      end else if (cout_tick) begin
        clock_out_pin_drive_out <= ~clock_out_pin_drive_out; // RULE_10
      end
    end
  end

endmodule // mcp_core

// ---- core/mcp_pkg.sv ----
// Constants, types and register map of the master clock and power mode controller.
// Assumes one 40 MHz system clock; oscillators arrive as one-cycle tick enables.
// Contract
// RULE_01: Selected source is divided by a software prescaler before CPU and peripherals.
// RULE_02: Source change waits on the old source until the new one is ready.
// RULE_03: Source changeover never truncates or doubles a master clock period.
// RULE_04: CPU, memory and each peripheral clock can be stopped individually.
// RULE_05: Four sources: crystal, user external clock, fast internal RC, slow internal RC.
// RULE_06: After reset the master clock is the fast internal RC divided by eight.
// RULE_07: Software may change prescaler and source any time after execution starts.
// RULE_08: Enabled guard switches to fast internal RC divided by eight on external failure.
// RULE_09: External clock failure raises an interrupt only when software enabled it.
// RULE_10: A configurable clock output drives an internal clock onto a pin.
// RULE_11: Gate one bits 7..0: adv timer, timer a, timer b, basic, serial, rsvd, spi, two-wire.
// RULE_12: Gate two bit 3 converter, bit 2 wakeup unit, other bits reserved.
// RULE_13: Wait stops only the CPU clock; any interrupt or reset resumes.
// RULE_14: Active halt regulator on stops CPU and peripherals; wakes on wakeup, external, reset.
// RULE_15: Active halt regulator off is the same but regulator off, slower wakeup.
// RULE_16: Halt stops CPU and peripherals, regulator off; wakes on external event or reset.
// RULE_17: Guard declares failure when no external edge within fixed slow-RC interval.
package mcp_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned REG_START_NS  = 2000;
  localparam int unsigned REG_START_CYC =
    (REG_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int unsigned AW       = 8;
  localparam int unsigned PRE_W    = 3;
  localparam int unsigned CNT_W    = 7;
  localparam int unsigned IRQ_W    = 2;

  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_POWER    = 8'h04;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h08;
  localparam logic [AW-1:0] OFS_GATE_ONE = 8'h0C;
  localparam logic [AW-1:0] OFS_GATE_TWO = 8'h10;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h18;

  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam int unsigned CTRL_PRE_LSB  = 2;
  localparam int unsigned CTRL_GUARD    = 5;
  localparam int unsigned CTRL_COUT_EN  = 6;
  localparam int unsigned CTRL_COUT_LSB = 7;
  localparam int unsigned CTRL_MEM_STOP = 9;

  localparam int unsigned PWR_MODE_LSB  = 0;
  localparam int unsigned PWR_ENTER     = 4;

  localparam int unsigned STAT_SRC_LSB  = 0;
  localparam int unsigned STAT_BUSY     = 2;
  localparam int unsigned STAT_RDY_LSB  = 3;
  localparam int unsigned STAT_PM_LSB   = 7;
  localparam int unsigned STAT_REG_ON   = 10;

  localparam int unsigned IRQ_FAIL      = 0;
  localparam int unsigned IRQ_SWITCHED  = 1;

  localparam logic [PRE_W-1:0] PRE_RESET      = 3'h3;
  localparam logic [7:0]       GATE_ONE_RESET = 8'hFF;
  localparam logic [7:0]       GATE_ONE_MASK  = 8'hFB;
  localparam logic [7:0]       GATE_TWO_RESET = 8'h0C;
  localparam logic [7:0]       GATE_TWO_MASK  = 8'h0C;

  typedef enum logic [1:0] {
    SRC_FAST_RC = 2'h0,
    SRC_SLOW_RC = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_UEXT = 2'h3
  } mcp_src_t;

  typedef enum logic [1:0] {
    LPM_WAIT   = 2'h0,
    LPM_AH_ON  = 2'h1,
    LPM_AH_OFF = 2'h2,
    LPM_HALT   = 2'h3
  } mcp_lpm_t;

  typedef enum logic [2:0] {
    PM_RUN    = 3'h0,
    PM_WAIT   = 3'h1,
    PM_AH_ON  = 3'h3,
    PM_AH_OFF = 3'h2,
    PM_HALT   = 3'h6,
    PM_WAKE   = 3'h7
  } mcp_pm_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } mcp_ahb_in_t;

  typedef struct packed {
    logic [3:0] tick;
    logic [3:0] ready;
  } mcp_osc_t;

  typedef struct packed {
    logic irq;
    logic ext_event;
    logic auto_wakeup_unit;
  } mcp_wake_t;

endpackage

// ---- sim/mcp_osc_model.sv ----
// Oscillator model: one tick enable and one ready flag per source.
// Assumes the bench sets ready and stops a source to fake a failure.
`timescale 1ns/1ps

module mcp_osc_model
  import mcp_pkg::*;
(
  input  wire logic [3:0] ready_in,
  input  wire logic [3:0] stop_in,
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  output mcp_osc_t        osc_out
);
  // Short periods keep the run brief; ratios only, not real rates
  localparam int PER[4] = '{2, 20, 3, 4};
  int cnt[4];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= '{0, 0, 0, 0};
      osc_out <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= (cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
        osc_out.tick[i] <= (cnt[i] == PER[i] - 1) && !stop_in[i];
      end
      osc_out.ready <= ready_in;
    end
  end
endmodule // mcp_osc_model

// ---- sim/mcp_core_sva.sv ----
// Port checker for the clock and power mode controller.
// Assumes a single clock domain and bind to every core instance.
`timescale 1ns/1ps

module mcp_core_sva
  import mcp_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire mcp_ahb_in_t ahb_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        master_tick_out,
  input wire logic        cpu_tick_out,
  input wire logic        mem_tick_out,
  input wire logic [7:0]  periph_one_tick_out,
  input wire logic [7:0]  periph_two_tick_out,
  input wire logic        clock_out_pin_drive_out,
  input wire logic        clock_out_oe_out,
  input wire logic        regulator_on_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wire acc = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  wire p_any = (|periph_one_tick_out) || (|periph_two_tick_out);
  sequence s_one_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence

  chk_resp_okay: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  chk_read_wait: assert property (acc && !ahb_in.hwrite |=> s_one_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (acc && ahb_in.hwrite |=> hreadyout_out)
    else $error("write stalled");
  chk_cpu_gated: assert property (cpu_tick_out |-> master_tick_out)
    else $error("cpu tick without master tick");
  chk_mem_gated: assert property (mem_tick_out |-> master_tick_out)
    else $error("memory tick without master tick");
  chk_periph_gated: assert property (p_any |-> master_tick_out)
    else $error("peripheral tick without master tick");
  chk_one_rsvd: assert property (periph_one_tick_out[2] == 1'b0)
    else $error("reserved gate one tick");
  chk_two_rsvd: assert property ((periph_two_tick_out & 8'hF3) == 8'h00)
    else $error("reserved gate two tick");
  chk_regoff_stop: assert property (!regulator_on_out |-> !cpu_tick_out && !p_any)
    else $error("ticks while regulator off");
  chk_pin_idle: assert property (!clock_out_oe_out [*2] |-> !clock_out_pin_drive_out)
    else $error("clock pin active while disabled");
endmodule // mcp_core_sva

bind mcp_core mcp_core_sva mcp_core_sva_inst (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .ahb_in(ahb_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .master_tick_out(master_tick_out), .cpu_tick_out(cpu_tick_out),
  .mem_tick_out(mem_tick_out), .periph_one_tick_out(periph_one_tick_out),
  .periph_two_tick_out(periph_two_tick_out),
  .clock_out_pin_drive_out(clock_out_pin_drive_out),
  .clock_out_oe_out(clock_out_oe_out), .regulator_on_out(regulator_on_out));

// ---- sim/testbench.sv ----
// Self-checking bench: AHB-Lite master tasks, tick counters, oscillator model.
// Assumes one 40 MHz clock; tick periods match the oscillator model.
`timescale 1ns/1ps

module testbench
  import mcp_pkg::*;
;
  logic        clock_in = 1'b0;
  logic        rst_b_in, hsel, hwrite, hready, irq, oe, pin, pin_q;
  logic        mt, cpu, mem, reg_on;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  p1, p2;
  logic [3:0]  rdy, stop;
  mcp_wake_t   wake;
  mcp_osc_t    osc;
  mcp_ahb_in_t ahb;
  int          err_total, n_checks;
  int          cnt[6], base[6], d[6];
  int          sl[4] = '{2, 3, 1, 0};
  int          per[4] = '{2, 20, 3, 4};
  logic [2:0]  wk[4] = '{3'h4, 3'h1, 3'h1, 3'h2};
  mcp_pm_t     pmc[4] = '{PM_WAIT, PM_AH_ON, PM_AH_OFF, PM_HALT};

  assign ahb = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, hready};
  always #12.5 clock_in = ~clock_in;

  mcp_osc_model mcp_osc_model_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .ready_in(rdy), .stop_in(stop), .osc_out(osc));
  mcp_core #(.GUARD_LSI_TICKS(2)) mcp_core_inst (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .ahb_in(ahb), .osc_in(osc), .wake_in(wake),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
    .master_tick_out(mt), .cpu_tick_out(cpu), .mem_tick_out(mem),
    .periph_one_tick_out(p1), .periph_two_tick_out(p2),
    .clock_out_pin_drive_out(pin), .clock_out_oe_out(oe),
    .regulator_on_out(reg_on), .irq_out(irq));

  // Counted mid-cycle, away from the edge that launches the ticks
  always @(negedge clock_in) begin
    cnt[0] += int'(mt === 1'b1);
    cnt[1] += int'(cpu === 1'b1);
    cnt[2] += int'(mem === 1'b1);
    cnt[3] += int'((|p1) === 1'b1);
    cnt[4] += int'((|p2) === 1'b1);
    cnt[5] += int'(pin !== pin_q);
    pin_q = pin;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic rdy_wait;
    int i;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (hready !== 1'b1 && i < 64);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    rdy_wait();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    xfer(1'b1, a, dat);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  task automatic span(input int n);
    step(8);
    base = cnt;
    step(n);
    foreach (d[i]) d[i] = cnt[i] - base[i];
  endtask
  task automatic irq_chk(input logic [31:0] e);
    step(3);
    cmp({31'h0, irq}, e);
  endtask
  task automatic pulse(input logic [2:0] w);
    wake <= w;
    step(1);
    wake <= '0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    step(30000);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    rdy = 4'h3;
    stop = 4'h0;
    wake = '0;
    rst_b_in = 1'b0;
    step(6);
    rst_b_in <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0C);
    rd_chk(OFS_GATE_ONE, 32'hFB);
    rd_chk(OFS_GATE_TWO, 32'h0C);
    rd_chk(OFS_STATUS, 32'h418);
    rd_chk(8'h40, 32'h0);
    span(160);
    cmp(d[0], 10);
    for (int n = 0; n < 4; n++) begin
      wr(OFS_CTRL, n << 2);
      span(64);
      cmp(d[0], 32 >> n);
      cmp(d[1], d[0]);
    end
    $display("test reset and prescaler done");
    wr(OFS_GATE_TWO, 32'hFF);
    rd_chk(OFS_GATE_TWO, 32'h0C);
    wr(OFS_CTRL, 32'h200);
    wr(OFS_GATE_ONE, 32'h0);
    span(64);
    cmp(d[2] + d[3], 0);
    cmp(d[1], 32);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_GATE_ONE, 32'h04);
    wr(OFS_GATE_TWO, 32'h08);
    span(64);
    cmp(d[3], 0);
    cmp(d[4] + d[2], 64);
    $display("test gating done");
    wr(OFS_CTRL, 32'h2);
    step(40);
    rd_chk(OFS_STATUS, 32'h41C);
    rdy <= 4'hF;
    step(40);
    rd_chk(OFS_STATUS, 32'h47A);
    foreach (sl[i]) begin
      wr(OFS_CTRL, sl[i]);
      step(100);
      rd_chk(OFS_STATUS, 32'h478 | sl[i]);
      span(per[sl[i]] * 8);
      cmp(d[0], 8);
    end
    wr(OFS_IRQ_MASK, 32'h2);
    irq_chk(1);
    wr(OFS_IRQ_MASK, 32'h1);
    irq_chk(0);
    wr(OFS_IRQ_STAT, 32'h2);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    $display("test switch done");
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CTRL, 32'h22);
    step(40);
    wr(OFS_IRQ_STAT, 32'h3);
    stop <= 4'h4;
    step(100);
    rd_chk(OFS_STATUS, 32'h478);
    rd_chk(OFS_CTRL, 32'h2C);
    irq_chk(0);
    wr(OFS_IRQ_MASK, 32'h1);
    irq_chk(1);
    wr(OFS_IRQ_STAT, 32'h3);
    irq_chk(0);
    stop <= 4'h0;
    $display("test guard done");
    wr(OFS_CTRL, 32'h40);
    span(64);
    cmp(d[5], 32);
    cmp({31'h0, oe}, 1);
    wr(OFS_CTRL, 32'h140);
    span(200);
    cmp(d[5], 10);
    wr(OFS_CTRL, 32'hC4);
    span(64);
    cmp(d[5], 32);
    wr(OFS_CTRL, 32'h1C0);
    span(96);
    cmp(d[5], 32);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_GATE_ONE, 32'hFF);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_POWER, m | 32'h10);
      span(64);
      cmp(d[1], 0);
      cmp(d[3], m == 0 ? 32 : 0);
      rd_chk(OFS_STATUS, {21'h0, (m < 2), pmc[m], 7'h78});
      if (m == 3) begin
        pulse(3'h1);
        step(20);
        cmp({31'h0, reg_on}, 0);
        rd_chk(OFS_STATUS, {24'h3, 8'h78});
      end
      pulse(wk[m]);
      step(20);
      xfer(1'b0, OFS_STATUS, 32'h0);
      cmp(q[9:7], m > 1 ? 7 : 0);
      step(REG_START_CYC);
      rd_chk(OFS_STATUS, 32'h478);
    end
    $display("test power modes done");
    conclude();
  end
endmodule // testbench
